// ===== logic/mcs_seq.sv
// measurement cycle sequencer: apb registers, cycle walk, result capture
//
// Summary of operation
// RL1: multiplexer walks auto-zero, diode, bridge resistor, thermistor and bridge sources.
// RL2: bridge repeat count n decoded from config bits 9:7 as one to 128.
// RL3: second temperature enable off drops temp-2 slots and their bridge runs.
// RL4: after reset a start routine measures bridge and bridge auto-zero first.
// RL5: with main temperature enabled, start routine adds temp-1 and its auto-zero.
// RL6: each cycle runs n bridge measurements before every slot in fixed order.
// RL7: the calibration controller starts and stops the sequence through a run bit.
// RL8: sensor zero shift is signed six bits, accepting -31 through 31.
// RL9: software keeps the zero shift inside -20 through 20 for guaranteed performance.
// RL10: temperature zero shift is a separate six-bit setting.
// RL11: remaining sensor offset is subtracted digitally from each bridge result.
// RL12: after the common-mode slot the cycle restarts at its first bridge run.
`timescale 1ns/1ps
`include "mcs_defs.svh"
module mcs_seq (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`MCS_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analog front end
	output logic [2:0] mux_sel,
	output logic [`MCS_ZS_W-1:0] zero_shift_code,
	output logic adc_start,
	input wire logic adc_done,
	input wire logic [`MCS_DW-1:0] adc_data
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	mcs_conv_if cv ();

	logic run_reg;
	logic [`MCS_CFG_W-1:0] cycle_config_word;
	logic [`MCS_ZS_W-1:0] zs_sensor_reg;
	logic [`MCS_ZS_W-1:0] zs_temp_reg;
	logic [`MCS_DW-1:0] offset_reg;
	logic [31:0] prdata_reg;

	mcs_pkg::mcs_state_t state_reg;
	logic init_reg;
	logic [1:0] init_idx_reg;
	logic [2:0] phase_reg;
	logic slot_reg;
	logic [7:0] rep_reg;

	logic [`MCS_DW-1:0] az_bridge_reg;
	logic [`MCS_DW-1:0] az_temp1_reg;
	logic [`MCS_DW-1:0] az_temp2_reg;
	logic [`MCS_DW-1:0] res_reg [`MCS_RES_NUM];

	logic [7:0] rep_last;
	logic second_temp_enable;
	logic main_temp_enable;
	mcs_pkg::mcs_src_t cur_src;
	logic cur_is_temp;
	logic conv_done;
	logic [`MCS_DW-1:0] conv_data;

	logic setup_ph;
	logic access_ph;
	logic wr_en;

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------
	function automatic logic addr_hit(input logic [`MCS_ADDR_W-1:0] a,
		input logic [`MCS_ADDR_W-1:0] target);
		addr_hit = (a == target);
	endfunction : addr_hit

	function automatic logic addr_mapped(input logic [`MCS_ADDR_W-1:0] a);
		logic hit;
		hit = addr_hit(a, `MCS_ADDR_CTRL) || addr_hit(a, `MCS_ADDR_CFG) ||
			addr_hit(a, `MCS_ADDR_ZS) || addr_hit(a, `MCS_ADDR_OFS) ||
			addr_hit(a, `MCS_ADDR_STAT);
		for (int i = 0; i < `MCS_RES_NUM; i++)
			if (addr_hit(a, `MCS_ADDR_RES_BASE + 8'(4 * i)))
				hit = 1'b1;
		addr_mapped = hit;
	endfunction : addr_mapped

	// temperature source selection, used for both channels
	function automatic mcs_pkg::mcs_src_t temp_src(input logic [1:0] code);
		case (code)
			2'h0: temp_src = mcs_pkg::SRC_DIODE_INT;
			2'h1: temp_src = mcs_pkg::SRC_DIODE_EXT;
			2'h2: temp_src = mcs_pkg::SRC_BRIDGE_RES;
			default: temp_src = mcs_pkg::SRC_THERM;
		endcase
	endfunction : temp_src

	// codes outside -31..31 are clamped: -32 has no matching positive step
	function automatic logic [`MCS_ZS_W-1:0] zs_clamp(input logic [`MCS_ZS_W-1:0] code);
		if (code == `MCS_ZS_NEG_OVER)
			zs_clamp = `MCS_ZS_NEG_MAX;
		else
			zs_clamp = code;
	endfunction : zs_clamp

	// ----------------------------------------------------------------
	// configuration decode
	// ----------------------------------------------------------------
	// n - 1 as an all-ones mask of the decoded width
	assign rep_last = 8'((9'h1 << cycle_config_word[`MCS_CFG_CNT_HI:`MCS_CFG_CNT_LO]) - 9'h1); // RL2
	assign second_temp_enable = cycle_config_word[`MCS_CFG_T2E];
	assign main_temp_enable = cycle_config_word[`MCS_CFG_T1E];

	// ----------------------------------------------------------------
	// source for the current step
	// ----------------------------------------------------------------
	always_comb
	begin
		cur_src = mcs_pkg::SRC_BRIDGE;
		cur_is_temp = 1'b0;
		if (init_reg)
		begin
			case (init_idx_reg)
				`MCS_INIT_BR: cur_src = mcs_pkg::SRC_BRIDGE; // RL4
				`MCS_INIT_BAZ: cur_src = mcs_pkg::SRC_ZERO_BRIDGE; // RL4
				`MCS_INIT_T1: cur_src = temp_src(cycle_config_word[`MCS_CFG_T1SRC_LO +: 2]); // RL5
				`MCS_INIT_T1AZ: cur_src = mcs_pkg::SRC_ZERO_TEMP; // RL5
				default: cur_src = mcs_pkg::SRC_BRIDGE;
			endcase
			cur_is_temp = init_idx_reg[1];
		end
		else if (slot_reg)
		begin
			case (phase_reg) // RL1
				`MCS_PH_T1AZ: cur_src = mcs_pkg::SRC_ZERO_TEMP;
				`MCS_PH_T1: cur_src = temp_src(cycle_config_word[`MCS_CFG_T1SRC_LO +: 2]);
				`MCS_PH_BAZ: cur_src = mcs_pkg::SRC_ZERO_BRIDGE;
				`MCS_PH_T2AZ: cur_src = mcs_pkg::SRC_ZERO_TEMP;
				`MCS_PH_T2: cur_src = temp_src(cycle_config_word[`MCS_CFG_T2SRC_LO +: 2]);
				default: cur_src = mcs_pkg::SRC_COMMON_MODE;
			endcase
			cur_is_temp = (phase_reg != `MCS_PH_BAZ) && (phase_reg != `MCS_PH_CM);
		end
	end

	// ----------------------------------------------------------------
	// conversion requests
	// ----------------------------------------------------------------
	assign cv.req = (state_reg == mcs_pkg::ST_ISSUE);
	assign cv.src = cur_src;
	// separate shift codes for sensor and temperature steps
	assign cv.zero_code = cur_is_temp ? zs_clamp(zs_temp_reg) : zs_clamp(zs_sensor_reg); // RL8 RL10
	assign conv_done = cv.done;
	assign conv_data = cv.data;

	mcs_conv_port u_conv (
		.pclk(pclk),
		.presetn(presetn),
		.cv(cv.conv),
		.mux_sel(mux_sel),
		.zero_shift_code(zero_shift_code),
		.adc_start(adc_start),
		.adc_done(adc_done),
		.adc_data(adc_data)
	);

	// ----------------------------------------------------------------
	// step control
	// ----------------------------------------------------------------
	// a clear of run lets the conversion in flight finish before idling
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			state_reg <= mcs_pkg::ST_IDLE;
		else
			case (state_reg)
				mcs_pkg::ST_IDLE:
					if (run_reg)
						state_reg <= mcs_pkg::ST_ISSUE; // RL7
				mcs_pkg::ST_ISSUE:
					state_reg <= mcs_pkg::ST_WAIT;
				mcs_pkg::ST_WAIT:
					if (conv_done)
						state_reg <= run_reg ? mcs_pkg::ST_ISSUE : mcs_pkg::ST_IDLE; // RL7
				default:
					state_reg <= mcs_pkg::ST_IDLE;
			endcase

	// ----------------------------------------------------------------
	// position in start routine and regular cycle
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			init_reg <= 1'b1;
			init_idx_reg <= `MCS_INIT_BR;
			phase_reg <= `MCS_PH_T1AZ;
			slot_reg <= 1'b0;
			rep_reg <= 8'h00;
		end
		else if (state_reg == mcs_pkg::ST_WAIT && conv_done)
		begin
			if (init_reg)
			begin
				if (init_idx_reg == `MCS_INIT_T1AZ ||
					(init_idx_reg == `MCS_INIT_BAZ && !main_temp_enable)) // RL5
				begin
					init_reg <= 1'b0;
					phase_reg <= `MCS_PH_T1AZ;
					slot_reg <= 1'b0;
					rep_reg <= 8'h00;
				end
				else
					init_idx_reg <= init_idx_reg + 2'h1; // RL4
			end
			else if (!slot_reg)
			begin
				if (rep_reg >= rep_last) // RL6
					slot_reg <= 1'b1;
				else
					rep_reg <= rep_reg + 8'h01;
			end
			else
			begin
				slot_reg <= 1'b0;
				rep_reg <= 8'h00;
				if (phase_reg == `MCS_PH_CM)
					phase_reg <= `MCS_PH_T1AZ; // RL12
				else if (phase_reg == `MCS_PH_BAZ && !second_temp_enable)
					phase_reg <= `MCS_PH_CM; // RL3
				else
					phase_reg <= phase_reg + 3'h1; // RL6
			end
		end

	// ----------------------------------------------------------------
	// auto-zero capture
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			az_bridge_reg <= '0;
			az_temp1_reg <= '0;
			az_temp2_reg <= '0;
		end
		else if (state_reg == mcs_pkg::ST_WAIT && conv_done)
		begin
			if (cur_src == mcs_pkg::SRC_ZERO_BRIDGE)
				az_bridge_reg <= conv_data;
			if (cur_src == mcs_pkg::SRC_ZERO_TEMP)
			begin
				if (!init_reg && phase_reg == `MCS_PH_T2AZ)
					az_temp2_reg <= conv_data;
				else
					az_temp1_reg <= conv_data;
			end
		end

	// ----------------------------------------------------------------
	// corrected results and raw common mode, one register per measured quantity
	// ----------------------------------------------------------------
	generate
		for (genvar g = 0; g < `MCS_RES_NUM; g++)
		begin : g_res
			logic take;
			logic [`MCS_DW-1:0] value;
			always_comb
			begin
				take = 1'b0;
				value = conv_data;
				case (g)
					mcs_pkg::RES_BRIDGE:
					begin
						take = (cur_src == mcs_pkg::SRC_BRIDGE);
						value = conv_data - az_bridge_reg - offset_reg; // RL11
					end
					mcs_pkg::RES_TEMP1:
					begin
						take = cur_is_temp && cur_src != mcs_pkg::SRC_ZERO_TEMP &&
							(init_reg || phase_reg == `MCS_PH_T1);
						value = conv_data - az_temp1_reg;
					end
					mcs_pkg::RES_TEMP2:
					begin
						take = cur_is_temp && !init_reg && phase_reg == `MCS_PH_T2;
						value = conv_data - az_temp2_reg;
					end
					default:
						take = (cur_src == mcs_pkg::SRC_COMMON_MODE);
				endcase
			end
			always_ff @(posedge pclk or negedge presetn)
				if (!presetn)
					res_reg[g] <= '0;
				else if (state_reg == mcs_pkg::ST_WAIT && conv_done && take)
					res_reg[g] <= value;
		end
	endgenerate

	// ----------------------------------------------------------------
	// apb slave: zero wait, read data prepared during setup
	// ----------------------------------------------------------------
	assign setup_ph = psel && !penable;
	assign access_ph = psel && penable;
	assign wr_en = access_ph && pwrite;
	assign pready = 1'b1;
	assign pslverr = access_ph && !addr_mapped(paddr);
	assign prdata = prdata_reg;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			run_reg <= 1'b0;
			cycle_config_word <= `MCS_CFG_RST;
			zs_sensor_reg <= `MCS_ZS_RST;
			zs_temp_reg <= `MCS_ZS_RST;
			offset_reg <= `MCS_OFS_RST;
		end
		else if (wr_en)
		begin
			if (addr_hit(paddr, `MCS_ADDR_CTRL))
				run_reg <= pwdata[`MCS_CTRL_RUN]; // RL7
			if (addr_hit(paddr, `MCS_ADDR_CFG))
				cycle_config_word <= pwdata[`MCS_CFG_W-1:0];
			if (addr_hit(paddr, `MCS_ADDR_ZS))
			begin
				zs_sensor_reg <= pwdata[`MCS_ZS_SENS_LO +: `MCS_ZS_W]; // RL8
				zs_temp_reg <= pwdata[`MCS_ZS_TEMP_LO +: `MCS_ZS_W]; // RL10
			end
			if (addr_hit(paddr, `MCS_ADDR_OFS))
				offset_reg <= pwdata[`MCS_DW-1:0];
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			prdata_reg <= 32'h0000_0000;
		else if (setup_ph && !pwrite)
		begin
			prdata_reg <= 32'h0000_0000;
			if (addr_hit(paddr, `MCS_ADDR_CTRL))
				prdata_reg[`MCS_CTRL_RUN] <= run_reg;
			if (addr_hit(paddr, `MCS_ADDR_CFG))
				prdata_reg[`MCS_CFG_W-1:0] <= cycle_config_word;
			if (addr_hit(paddr, `MCS_ADDR_ZS))
			begin
				prdata_reg[`MCS_ZS_SENS_LO +: `MCS_ZS_W] <= zs_sensor_reg;
				prdata_reg[`MCS_ZS_TEMP_LO +: `MCS_ZS_W] <= zs_temp_reg;
			end
			if (addr_hit(paddr, `MCS_ADDR_OFS))
				prdata_reg[`MCS_DW-1:0] <= offset_reg;
			if (addr_hit(paddr, `MCS_ADDR_STAT))
			begin
				prdata_reg[`MCS_STAT_PH_LO +: 3] <= phase_reg;
				prdata_reg[`MCS_STAT_SLOT] <= slot_reg;
				prdata_reg[`MCS_STAT_INIT] <= init_reg;
				prdata_reg[`MCS_STAT_BUSY] <= (state_reg != mcs_pkg::ST_IDLE);
				prdata_reg[`MCS_STAT_SRC_LO +: 3] <= cur_src;
				prdata_reg[`MCS_STAT_REP_LO +: 8] <= rep_reg;
			end
			for (int i = 0; i < `MCS_RES_NUM; i++)
				if (addr_hit(paddr, `MCS_ADDR_RES_BASE + 8'(4 * i)))
					prdata_reg[`MCS_DW-1:0] <= res_reg[i];
		end
endmodule : mcs_seq

// ===== logic/mcs_defs.svh
// register map, field positions, reset values and sequence constants
`ifndef MCS_DEFS_SVH
`define MCS_DEFS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define MCS_ADDR_W 8
`define MCS_ADDR_CTRL 8'h00
`define MCS_ADDR_CFG 8'h04
`define MCS_ADDR_ZS 8'h08
`define MCS_ADDR_OFS 8'h0C
`define MCS_ADDR_STAT 8'h10
`define MCS_ADDR_RES_BASE 8'h14
`define MCS_RES_NUM 4

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MCS_CTRL_RUN 0
`define MCS_CFG_T1SRC_LO 0
`define MCS_CFG_T2SRC_LO 2
`define MCS_CFG_CNT_LO 7
`define MCS_CFG_CNT_HI 9
`define MCS_CFG_T2E 11
`define MCS_CFG_T1E 12
`define MCS_CFG_W 13
`define MCS_ZS_SENS_LO 0
`define MCS_ZS_TEMP_LO 8
`define MCS_ZS_W 6
`define MCS_DW 16
`define MCS_STAT_PH_LO 0
`define MCS_STAT_SLOT 3
`define MCS_STAT_INIT 4
`define MCS_STAT_BUSY 5
`define MCS_STAT_SRC_LO 8
`define MCS_STAT_REP_LO 16

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MCS_CFG_RST 13'h1000
`define MCS_ZS_RST 6'h00
`define MCS_OFS_RST 16'h0000

// ----------------------------------------------------------------
// zero shift limits, two's complement in six bits
// ----------------------------------------------------------------
`define MCS_ZS_POS_MAX 6'h1F
`define MCS_ZS_NEG_MAX 6'h21
`define MCS_ZS_NEG_OVER 6'h20

// ----------------------------------------------------------------
// regular cycle phases and start routine steps
// ----------------------------------------------------------------
`define MCS_PH_T1AZ 3'h0
`define MCS_PH_T1 3'h1
`define MCS_PH_BAZ 3'h2
`define MCS_PH_T2AZ 3'h3
`define MCS_PH_T2 3'h4
`define MCS_PH_CM 3'h5
`define MCS_INIT_BR 2'h0
`define MCS_INIT_BAZ 2'h1
`define MCS_INIT_T1 2'h2
`define MCS_INIT_T1AZ 2'h3

`endif

// ===== logic/mcs_pkg.sv
// types shared by the measurement cycle sequencer
package mcs_pkg;

	typedef enum logic [2:0] {
		SRC_BRIDGE,
		SRC_ZERO_BRIDGE,
		SRC_ZERO_TEMP,
		SRC_DIODE_INT,
		SRC_DIODE_EXT,
		SRC_BRIDGE_RES,
		SRC_THERM,
		SRC_COMMON_MODE
	} mcs_src_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ISSUE,
		ST_WAIT
	} mcs_state_t;

	typedef enum logic [1:0] {
		RES_BRIDGE,
		RES_TEMP1,
		RES_TEMP2,
		RES_COMMON
	} mcs_res_t;

endpackage : mcs_pkg

// ===== logic/mcs_conv_if.sv
// conversion request channel between sequencer core and converter port
`timescale 1ns/1ps
`include "mcs_defs.svh"
interface mcs_conv_if;
	logic req;
	mcs_pkg::mcs_src_t src;
	logic [`MCS_ZS_W-1:0] zero_code;
	logic done;
	logic [`MCS_DW-1:0] data;

	modport seq (output req, output src, output zero_code, input done, input data);
	modport conv (input req, input src, input zero_code, output done, output data);
endinterface : mcs_conv_if

// ===== logic/mcs_conv_port.sv
// drives multiplexer, zero shift and converter handshake for one conversion at a time
`timescale 1ns/1ps
`include "mcs_defs.svh"
module mcs_conv_port (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// sequencer side
	mcs_conv_if.conv cv,
	// analog front end side
	output logic [2:0] mux_sel,
	output logic [`MCS_ZS_W-1:0] zero_shift_code,
	output logic adc_start,
	input wire logic adc_done,
	input wire logic [`MCS_DW-1:0] adc_data
);
	logic busy_reg;
	logic start_reg;
	logic done_reg;
	logic [`MCS_DW-1:0] data_reg;
	mcs_pkg::mcs_src_t src_reg;
	logic [`MCS_ZS_W-1:0] zs_reg;

	// ----------------------------------------------------------------
	// source and shift held steady for the whole conversion
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			src_reg <= mcs_pkg::SRC_ZERO_BRIDGE;
			zs_reg <= `MCS_ZS_RST;
		end
		else if (cv.req && !busy_reg)
		begin
			src_reg <= cv.src;
			zs_reg <= cv.zero_code;
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			busy_reg <= 1'b0;
			start_reg <= 1'b0;
		end
		else
		begin
			start_reg <= cv.req && !busy_reg;
			if (cv.req && !busy_reg)
				busy_reg <= 1'b1;
			else if (adc_done && !start_reg)
				busy_reg <= 1'b0;
		end

	// ----------------------------------------------------------------
	// result handed back as a one-cycle pulse
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			done_reg <= 1'b0;
			data_reg <= '0;
		end
		else
		begin
			done_reg <= busy_reg && !start_reg && adc_done;
			if (busy_reg && !start_reg && adc_done)
				data_reg <= adc_data;
		end

	assign mux_sel = src_reg;
	assign zero_shift_code = zs_reg;
	assign adc_start = start_reg;
	assign cv.done = done_reg;
	assign cv.data = data_reg;
endmodule : mcs_conv_port

// ===== testbench/mcs_seq_asserts.sv
// concurrent checks on the sequencer's converter-side ports
`timescale 1ns/1ps
`include "mcs_defs.svh"
module mcs_seq_asserts (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// converter side
	input wire logic [2:0] mux_sel,
	input wire logic [`MCS_ZS_W-1:0] zero_shift_code,
	input wire logic adc_start,
	input wire logic adc_done
);
	logic pend;
	logic [3:0] nstart;
	logic [2:0] last_src;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// --------------------
	// request bookkeeping
	// --------------------
	// count saturates: only the first few starts need telling apart
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pend <= 1'b0;
			nstart <= 4'h0;
			last_src <= 3'h0;
		end
		else if (adc_start)
		begin
			pend <= 1'b1;
			nstart <= (nstart == 4'hF) ? nstart : nstart + 4'h1;
			last_src <= mux_sel;
		end
		else if (adc_done)
			pend <= 1'b0;
	end

	// --------------------
	// properties
	// --------------------
	property p_start_pulse;
		adc_start |=> !adc_start [*2];
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
	property p_src_hold;
		!adc_start |-> $stable(mux_sel);
	endproperty
	a_src_hold: assert property (p_src_hold) else $error("source moved mid conversion");
	property p_zs_hold;
		!adc_start |-> $stable(zero_shift_code);
	endproperty
	a_zs_hold: assert property (p_zs_hold) else $error("shift moved mid conversion");
	property p_no_neg32;
		adc_start |-> zero_shift_code != 6'h20;
	endproperty
	a_no_neg32: assert property (p_no_neg32) else $error("shift code out of range");
	property p_first_bridge;
		adc_start && nstart == 4'h0 |-> mux_sel == 3'h0;
	endproperty
	a_first_bridge: assert property (p_first_bridge) else $error("start not bridge");
	property p_second_baz;
		adc_start && nstart == 4'h1 |-> mux_sel == 3'h1;
	endproperty
	a_second_baz: assert property (p_second_baz) else $error("no bridge zero");
	property p_slot_then_bridge;
		adc_start && nstart > 4'h3 && last_src != 3'h0 |-> mux_sel == 3'h0;
	endproperty
	a_slot_then_bridge: assert property (p_slot_then_bridge) else $error("slot run");
	property p_one_pending;
		adc_start |-> !pend;
	endproperty
	a_one_pending: assert property (p_one_pending) else $error("start while busy");
endmodule : mcs_seq_asserts

bind mcs_seq mcs_seq_asserts u_chk (.pclk(pclk), .presetn(presetn), .mux_sel(mux_sel),
	.zero_shift_code(zero_shift_code), .adc_start(adc_start), .adc_done(adc_done));

// ===== testbench/mcs_adc_model.sv
// behavioural converter answering the sequencer's conversion requests
`timescale 1ns/1ps
`include "mcs_defs.svh"
module mcs_adc_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// conversion handshake
	input wire logic adc_start,
	input wire logic slow,
	output logic adc_done,
	output logic [`MCS_DW-1:0] adc_data
);
	int d;

	initial
	begin
		adc_done = 1'b0;
		adc_data = 16'h5A5A;
		forever
		begin
			@(posedge pclk);
			if (presetn && adc_start)
			begin
				// never answers in the cycle after the start itself
				d = slow ? 12 : $urandom_range(2, 4);
				repeat (d) @(posedge pclk);
				adc_done <= 1'b1;
				adc_data <= 16'($urandom);
				@(posedge pclk);
				adc_done <= 1'b0;
				// stale word is inverted so a late read cannot pass
				adc_data <= ~adc_data;
			end
		end
	end
endmodule : mcs_adc_model

// ===== testbench/tb_top.sv
// self-checking bench for the measurement cycle sequencer
`timescale 1ns/1ps
`include "mcs_defs.svh"
module tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
	logic adc_start, adc_done;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] mux_sel, cur;
	logic [5:0] zero_shift_code, zs_s, zs_t;
	logic [15:0] adc_data, ofs, exp_br, exp_cm, baz, tz, exp_t;
	logic [12:0] cfg;
	logic [2:0] srcq[$];
	logic [5:0] zsq[$];
	int failures, num_checks, n, n2, tot, i, junk;

	mcs_seq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mux_sel(mux_sel), .zero_shift_code(zero_shift_code),
		.adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data));
	mcs_adc_model u_adc (.pclk(pclk), .presetn(presetn), .adc_start(adc_start), .slow(slow),
		.adc_done(adc_done), .adc_data(adc_data));

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// --------------------
	// conversion monitor
	// --------------------
	always @(posedge pclk)
	begin
		if (presetn && adc_start)
		begin
			srcq.push_back(mux_sel);
			zsq.push_back(zero_shift_code);
			cur = mux_sel;
		end
		if (presetn && adc_done)
		begin
			if (cur == 3'h0)
				exp_br = adc_data - baz - ofs;
			if (cur == 3'h1)
				baz = adc_data;
			// each regular-cycle temperature slot follows its own auto-zero (the start routine takes temp-1 before it), so the latest one applies
			if (cur == 3'h2)
				tz = adc_data;
			if (cur > 3'h2 && cur < 3'h7)
				exp_t = adc_data - tz;
			if (cur == 3'h7)
				exp_cm = adc_data;
		end
	end

	// --------------------
	// expectations
	// --------------------
	function automatic logic [2:0] exp_src(int k, logic [12:0] c);
		int m;
		int j;
		int s;
		m = 1 << c[9:7];
		s = c[12] ? 4 : 2;
		if (k < s)
			return k == 0 ? 3'h0 : k == 1 ? 3'h1 : k == 2 ? 3'h3 + c[1:0] : 3'h2;
		j = (k - s) % ((m + 1) * (c[11] ? 6 : 4));
		if (j % (m + 1) < m)
			return 3'h0;
		s = j / (m + 1);
		if (!c[11] && s == 3)
			s = 5;
		return s == 0 ? 3'h2 : s == 1 ? 3'h3 + c[1:0] : s == 2 ? 3'h1 :
			s == 3 ? 3'h2 : s == 4 ? 3'h3 + c[3:2] : 3'h7;
	endfunction : exp_src

	function automatic logic [5:0] exp_zs(logic [5:0] z);
		return z == 6'h20 ? 6'h21 : z;
	endfunction : exp_zs

	task tally_and_finish;
		if (failures == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	task chk(string nm, logic [31:0] s, logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task guard(int k, int lim);
		if (k >= lim)
		begin
			failures++;
			tally_and_finish();
		end
	endtask : guard

	task apb(logic w, logic [7:0] a, logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		guard(k, 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// --------------------
	// main sequence
	// --------------------
	initial
	begin
		{psel, penable, pwrite, slow, paddr, pwdata} = '0;
		{failures, num_checks, baz, ofs, exp_br, exp_cm} = '0;
		presetn = 1'b0;
		junk = $urandom(57702);
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 4; i++)
		begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk("reset value", rd, i == 1 ? 32'h1000 : 32'h0);
		end
		apb(1'b1, 8'h40, 32'hFFFF);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped data", rd, 32'h0);
		chk("unmapped error", {31'h0, err}, 32'h1);
		for (int sc = 0; sc < 4; sc++)
		begin
			presetn <= 1'b0;
			repeat (2) @(posedge pclk);
			presetn <= 1'b1;
			srcq.delete();
			zsq.delete();
			baz = 16'h0;
			tz = 16'h0;
			slow = (sc == 3);
			cfg = 13'($urandom) & 13'h000F;
			cfg[9:7] = sc == 0 ? 3'h0 : sc == 1 ? 3'h7 : 3'($urandom_range(1, 6));
			cfg[11] = (sc == 1 || sc == 2);
			cfg[12] = (sc != 2);
			// corner codes first, then the guaranteed span only
			zs_s = sc == 0 ? 6'h20 : sc == 1 ? 6'h1F : 6'($urandom_range(0, 40) - 20);
			zs_t = 6'($urandom);
			ofs = 16'($urandom);
			apb(1'b1, 8'h04, {19'h0, cfg});
			apb(1'b1, 8'h08, {18'h0, zs_t, 2'h0, zs_s});
			apb(1'b1, 8'h0C, {16'h0, ofs});
			apb(1'b0, 8'h04, 32'h0);
			chk("config", rd, {19'h0, cfg});
			n = 1 << cfg[9:7];
			tot = (cfg[12] ? 4 : 2) + (n + 1) * (cfg[11] ? 6 : 4) + n + 1;
			apb(1'b1, 8'h00, 32'h1);
			i = 0;
			while (srcq.size() < tot && i < 30000)
			begin
				@(posedge pclk);
				i++;
			end
			guard(i, 30000);
			apb(1'b1, 8'h00, 32'h0);
			i = 0;
			do
			begin
				apb(1'b0, 8'h10, 32'h0);
				i++;
			end
			while (rd[5] !== 1'b0 && i < 100);
			guard(i, 100);
			n2 = srcq.size();
			repeat (20) @(posedge pclk);
			chk("halted", srcq.size(), n2);
			for (i = 0; i < tot; i++)
			begin
				chk("source", srcq[i], exp_src(i, cfg));
				if (srcq[i] == 3'h0)
					chk("sensor shift", zsq[i], exp_zs(zs_s));
				if (srcq[i] > 3'h2 && srcq[i] < 3'h7)
					chk("temp shift", zsq[i], exp_zs(zs_t));
			end
			apb(1'b0, 8'h14, 32'h0);
			chk("bridge result", rd, {16'h0, exp_br});
			apb(1'b0, 8'h20, 32'h0);
			chk("common mode", rd, {16'h0, exp_cm});
			// last temperature slot of the run is temp-2 whenever it is enabled
			apb(1'b0, cfg[11] ? 8'h1C : 8'h18, 32'h0);
			chk("temp result", rd, {16'h0, exp_t});
		end
		tally_and_finish();
	end
endmodule : tb_top
